// ---- src/dct_map.svh ----
// Register offsets, field positions and reset values of the compare trigger timer.
//
// Summary of operation
// - Eight-bit up-counter, software readable and writable.
// - Counter overflow sets the overflow flag.
// - Reset clears the counter to zero.
// - Two compare registers, reset to all ones.
// - Equality sets match flag, optional interrupt.
// - No compare during write to that register.
// - Match B flag requests interrupt when enabled.
// - Match A flag requests interrupt when enabled.
// - Overflow flag requests interrupt when enabled.
// - Clear select: none, match A, B, pin.
// - Internal prescaled clocks, code zero stops counting.
// - External clock rising, falling or both edges.
// - Compare matches drive the wave output pin.
// - Trigger pin edge can start counting.
// - Count stop halts counting when counter clears.
// - Exactly three interrupt sources exist.
// - Overflow only on wrap from ones to zero.
// - Flags clear by read-one then write-zero.
// - Output select keeps, drives low, high, toggles.
// - Trigger edge select; match clear stops counting.
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DCT_OFS_COUNT     8'h00
`define DCT_OFS_CMP_A     8'h04
`define DCT_OFS_CMP_B     8'h08
`define DCT_OFS_CTRL0     8'h0C
`define DCT_OFS_STATUS    8'h10
`define DCT_OFS_CTRL1     8'h14

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DCT_RST_COUNT     8'h00
`define DCT_RST_CMP       8'hFF
`define DCT_RST_CTRL      8'h00
`define DCT_ONES          8'hFF

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DCT_C0_IEN_B      7
`define DCT_C0_IEN_A      6
`define DCT_C0_IEN_OVF    5
`define DCT_C0_CLR_HI     4
`define DCT_C0_CLR_LO     3
`define DCT_C0_CKS_HI     2
`define DCT_ST_FLAG_B     7
`define DCT_ST_FLAG_A     6
`define DCT_ST_FLAG_OVF   5
`define DCT_ST_RSV        4
`define DCT_ST_OSB_HI     3
`define DCT_ST_OSB_LO     2
`define DCT_ST_OSA_HI     1
`define DCT_ST_OSA_LO     0
`define DCT_C1_TEDGE_HI   4
`define DCT_C1_TEDGE_LO   3
`define DCT_C1_TRIGGER_START_ENABLE       2
`define DCT_C1_SUB        0
`define DCT_C1_RSV_MASK   8'hE2
`define DCT_PRESC_W       7

`endif

// ---- src/dct_pkg.sv ----
// Types shared by the compare trigger timer.
package dct_pkg;

  typedef logic [7:0] dct_byte_t;

  typedef enum logic [1:0] {
    DCT_WA_KEEP = 2'b00,
    DCT_WA_LOW  = 2'b01,
    DCT_WA_HIGH = 2'b10,
    DCT_WA_TOG  = 2'b11
  } dct_wave_act_e;

  typedef enum logic [1:0] {
    DCT_CLR_NONE = 2'b00,
    DCT_CLR_MA   = 2'b01,
    DCT_CLR_MB   = 2'b10,
    DCT_CLR_PIN  = 2'b11
  } dct_clr_sel_e;

  typedef enum logic {
    DCT_IDLE = 1'b0,
    DCT_RUN  = 1'b1
  } dct_run_e;

endpackage

// ---- src/dct_timer.sv ----
// Eight-bit compare trigger timer with APB register access.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "dct_map.svh"

module dct_timer (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer pins.
  input  wire logic        ext_clock_pin,
  input  wire logic        ext_clear_pin,
  input  wire logic        trigger_pin,
  output logic             wave_out_pin,
  // Interrupt requests.
  output logic             irq_match_a,
  output logic             irq_match_b,
  output logic             irq_overflow
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  dct_pkg::dct_byte_t count_reg;
  dct_pkg::dct_byte_t compare_a_reg;
  dct_pkg::dct_byte_t compare_b_reg;
  dct_pkg::dct_byte_t ctrl0_reg;
  dct_pkg::dct_byte_t ctrl1_reg;
  logic [3:0]         out_sel;
  logic               match_flag_a;
  logic               match_flag_b;
  logic               overflow_flag;
  logic               arm_a;
  logic               arm_b;
  logic               arm_ovf;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_status;
  logic rd_status;
  dct_pkg::dct_byte_t wbyte;

  assign setup     = psel & ~penable;
  assign acc       = psel & penable;
  assign wr        = acc & pwrite;
  assign rd        = acc & ~pwrite;
  assign wbyte     = pwdata[7:0];
  assign mapped    = (paddr == `DCT_OFS_COUNT) | (paddr == `DCT_OFS_CMP_A)
                   | (paddr == `DCT_OFS_CMP_B) | (paddr == `DCT_OFS_CTRL0)
                   | (paddr == `DCT_OFS_STATUS) | (paddr == `DCT_OFS_CTRL1);
  assign wr_count  = wr & (paddr == `DCT_OFS_COUNT);
  assign wr_cmp_a  = wr & (paddr == `DCT_OFS_CMP_A);
  assign wr_cmp_b  = wr & (paddr == `DCT_OFS_CMP_B);
  assign wr_status = wr & (paddr == `DCT_OFS_STATUS);
  assign rd_status = rd & (paddr == `DCT_OFS_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = acc & ~mapped;

  // Read data is captured in the setup cycle so the access phase shows a flop.
  dct_pkg::dct_byte_t next_rbyte;

  always_comb begin
    next_rbyte = 8'h00;
    unique case (paddr)
      `DCT_OFS_COUNT:  next_rbyte = count_reg;
      `DCT_OFS_CMP_A:  next_rbyte = compare_a_reg;
      `DCT_OFS_CMP_B:  next_rbyte = compare_b_reg;
      `DCT_OFS_CTRL0:  next_rbyte = ctrl0_reg;
      `DCT_OFS_STATUS: next_rbyte = {match_flag_b, match_flag_a, overflow_flag, 1'b1, out_sel};
      `DCT_OFS_CTRL1:  next_rbyte = ctrl1_reg | `DCT_C1_RSV_MASK;
      default:         next_rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= {24'h000000, next_rbyte};
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_reg <= `DCT_RST_CMP;
      compare_b_reg <= `DCT_RST_CMP;
      ctrl0_reg     <= `DCT_RST_CTRL;
      ctrl1_reg     <= `DCT_RST_CTRL;
      out_sel       <= 4'h0;
    end else if (wr) begin
      if (paddr == `DCT_OFS_CMP_A) begin
        compare_a_reg <= wbyte;
      end
      if (paddr == `DCT_OFS_CMP_B) begin
        compare_b_reg <= wbyte;
      end
      if (paddr == `DCT_OFS_CTRL0) begin
        ctrl0_reg <= wbyte;
      end
      if (paddr == `DCT_OFS_CTRL1) begin
        ctrl1_reg <= wbyte & ~`DCT_C1_RSV_MASK;
      end
      if (paddr == `DCT_OFS_STATUS) begin
        out_sel <= wbyte[3:0];
      end
    end
  end

  logic [2:0] cks;
  logic       sub_sel;
  logic       trigger_start_enable;
  logic [1:0] tedge;
  dct_pkg::dct_clr_sel_e clr_sel;

  assign cks     = ctrl0_reg[`DCT_C0_CKS_HI:0];
  assign clr_sel = dct_pkg::dct_clr_sel_e'(ctrl0_reg[`DCT_C0_CLR_HI:`DCT_C0_CLR_LO]);
  assign sub_sel = ctrl1_reg[`DCT_C1_SUB];
  assign trigger_start_enable    = ctrl1_reg[`DCT_C1_TRIGGER_START_ENABLE];
  assign tedge   = ctrl1_reg[`DCT_C1_TEDGE_HI:`DCT_C1_TEDGE_LO];

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Index 0 is the external clock, 1 the external clear, 2 the trigger.
  logic [2:0] pin_raw;
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  assign pin_raw = {trigger_pin, ext_clear_pin, ext_clock_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          pin_lvl[gi] <= 1'b0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            pin_lvl[gi] <= s3;
          end
        end
      end
      assign pin_rise[gi] = (s2 == s3) & s3 & ~pin_lvl[gi];
      assign pin_fall[gi] = (s2 == s3) & ~s3 & pin_lvl[gi];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Prescaler and count source
  // --------------------------------------------------------------------------
  logic [`DCT_PRESC_W-1:0] presc;
  logic [`DCT_PRESC_W-1:0] div_mask;
  logic [2:0]              div_w;
  logic                    tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  // A divided clock falls when all bits below its stage are ones.
  assign div_w    = {cks[1:0], 1'b0} + {2'b00, sub_sel};
  assign div_mask = 7'h7F >> (3'd7 - div_w);

  always_comb begin
    tick = 1'b0;
    if (!cks[2]) begin
      tick = (cks[1:0] != 2'b00) & ((presc & div_mask) == div_mask);
    end else begin
      unique case (cks[1:0])
        2'b00: tick = 1'b0;
        2'b01: tick = pin_rise[0];
        2'b10: tick = pin_fall[0];
        2'b11: tick = pin_rise[0] | pin_fall[0];
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Trigger start and count stop
  // --------------------------------------------------------------------------
  dct_pkg::dct_run_e run_st;
  logic trig_evt;
  logic match_clr;
  logic pin_clr;
  logic counting;

  always_comb begin
    trig_evt = 1'b0;
    unique case (tedge)
      2'b00: trig_evt = 1'b0;
      2'b01: trig_evt = pin_rise[2];
      2'b10: trig_evt = pin_fall[2];
      2'b11: trig_evt = pin_rise[2] | pin_fall[2];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_st <= dct_pkg::DCT_IDLE;
    end else begin
      unique case (run_st)
        dct_pkg::DCT_IDLE: begin
          if (trigger_start_enable && trig_evt) begin
            run_st <= dct_pkg::DCT_RUN;
          end
        end
        dct_pkg::DCT_RUN: begin
          if (trigger_start_enable && (match_clr || pin_clr)) begin
            run_st <= dct_pkg::DCT_IDLE;
          end
        end
      endcase
    end
  end

  assign counting = ~trigger_start_enable | (run_st == dct_pkg::DCT_RUN);

  // --------------------------------------------------------------------------
  // Compare and counter
  // --------------------------------------------------------------------------
  logic eq_a;
  logic eq_b;
  logic eq_a_q;
  logic eq_b_q;
  logic match_a;
  logic match_b;
  logic inc;
  logic wrap;

  // A compare register is not compared in the cycle it is written.
  assign eq_a    = (count_reg == compare_a_reg) & ~wr_cmp_a;
  assign eq_b    = (count_reg == compare_b_reg) & ~wr_cmp_b;
  assign match_a = eq_a & ~eq_a_q;
  assign match_b = eq_b & ~eq_b_q;

  assign match_clr = ((clr_sel == dct_pkg::DCT_CLR_MA) & match_a)
                   | ((clr_sel == dct_pkg::DCT_CLR_MB) & match_b);
  assign pin_clr   = (clr_sel == dct_pkg::DCT_CLR_PIN) & pin_rise[1];
  assign inc       = tick & counting;
  assign wrap      = inc & (count_reg == `DCT_ONES) & ~wr_count & ~match_clr & ~pin_clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_a_q <= 1'b0;
      eq_b_q <= 1'b0;
    end else begin
      eq_a_q <= eq_a;
      eq_b_q <= eq_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `DCT_RST_COUNT;
    end else if (wr_count) begin
      count_reg <= wbyte;
    end else if (match_clr || pin_clr) begin
      count_reg <= `DCT_RST_COUNT;
    end else if (inc) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------------
  // A flag clears only when the last status read saw it at one; a new set wins.
  logic next_flag_a;
  logic next_flag_b;
  logic next_flag_ovf;

  assign next_flag_a   = match_a | (match_flag_a & ~(wr_status & arm_a & ~wbyte[`DCT_ST_FLAG_A]));
  assign next_flag_b   = match_b | (match_flag_b & ~(wr_status & arm_b & ~wbyte[`DCT_ST_FLAG_B]));
  assign next_flag_ovf = wrap | (overflow_flag & ~(wr_status & arm_ovf & ~wbyte[`DCT_ST_FLAG_OVF]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag_a  <= 1'b0;
      match_flag_b  <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      match_flag_a  <= next_flag_a;
      match_flag_b  <= next_flag_b;
      overflow_flag <= next_flag_ovf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_a   <= 1'b0;
      arm_b   <= 1'b0;
      arm_ovf <= 1'b0;
    end else if (rd_status) begin
      arm_a   <= prdata[`DCT_ST_FLAG_A];
      arm_b   <= prdata[`DCT_ST_FLAG_B];
      arm_ovf <= prdata[`DCT_ST_FLAG_OVF];
    end else if (wr_status) begin
      arm_a   <= 1'b0;
      arm_b   <= 1'b0;
      arm_ovf <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt requests
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_match_a  <= 1'b0;
      irq_match_b  <= 1'b0;
      irq_overflow <= 1'b0;
    end else begin
      irq_match_b  <= next_flag_b & ctrl0_reg[`DCT_C0_IEN_B];
      irq_match_a  <= next_flag_a & ctrl0_reg[`DCT_C0_IEN_A];
      irq_overflow <= next_flag_ovf & ctrl0_reg[`DCT_C0_IEN_OVF];
    end
  end

  // --------------------------------------------------------------------------
  // Waveform output
  // --------------------------------------------------------------------------
  function automatic logic wave_apply(input logic cur, input logic [1:0] code);
    dct_pkg::dct_wave_act_e act;
    act = dct_pkg::dct_wave_act_e'(code);
    unique case (act)
      dct_pkg::DCT_WA_KEEP: wave_apply = cur;
      dct_pkg::DCT_WA_LOW:  wave_apply = 1'b0;
      dct_pkg::DCT_WA_HIGH: wave_apply = 1'b1;
      dct_pkg::DCT_WA_TOG:  wave_apply = ~cur;
    endcase
  endfunction

  // Match B is applied after match A, so B acts on A's result when both land together.
  logic next_wave_a;
  logic next_wave;

  assign next_wave_a = match_a ? wave_apply(wave_out_pin, out_sel[1:0]) : wave_out_pin;
  assign next_wave   = match_b ? wave_apply(next_wave_a, out_sel[3:2]) : next_wave_a;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out_pin <= 1'b0;
    end else begin
      wave_out_pin <= next_wave;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ovf_wrap: assert property (wrap |=> overflow_flag && count_reg == 8'h00)
    else $error("overflow flag not set on wrap");
  chk_ovf_cause: assert property ($rose(overflow_flag) |-> $past(count_reg) == 8'hFF)
    else $error("overflow flag set without wrap");
  chk_match_flag: assert property (match_a |=> match_flag_a ##0 $past(count_reg) == $past(compare_a_reg))
    else $error("match flag a not set on equality");
  chk_cmp_suppress: assert property (wr_cmp_b |-> !match_b)
    else $error("compare active during its write");
  chk_irq_b: assert property ($rose(match_flag_b) && $past(ctrl0_reg[7]) |-> irq_match_b)
    else $error("match b interrupt missing");
  chk_irq_a: assert property ($rose(match_flag_a) && $past(ctrl0_reg[6]) |-> irq_match_a)
    else $error("match a interrupt missing");
  chk_irq_ovf: assert property (!$past(ctrl0_reg[5]) |-> !irq_overflow)
    else $error("overflow interrupt while disabled");
  chk_flag_clear: assert property ($fell(match_flag_a) |-> $past(arm_a) && $past(wr_status))
    else $error("match flag a cleared without read first");
  chk_clear_b: assert property (clr_sel == dct_pkg::DCT_CLR_MB && match_b && !wr_count |=> count_reg == 8'h00)
    else $error("counter not cleared on match b");
  chk_stop_count: assert property (cks[1:0] == 2'b00 && !wr_count && !match_clr && !pin_clr |=> $stable(count_reg))
    else $error("counter moved with clock stopped");
  chk_trig_halt: assert property (trigger_start_enable && match_clr |=> run_st == dct_pkg::DCT_IDLE)
    else $error("count not halted on clear");
  chk_wave_low: assert property (match_a && out_sel[1:0] == 2'b01 && !match_b |=> !wave_out_pin)
    else $error("wave output not driven low");

  cov_overflow: cover property (wrap);
  cov_trig_start: cover property (trigger_start_enable && trig_evt ##1 run_st == dct_pkg::DCT_RUN);
  cov_wave_toggle: cover property (match_a && out_sel[1:0] == 2'b11);
  cov_pin_clear: cover property (pin_clr);

endmodule

// ---- test/dct_pin_src.sv ----
// Behavioural source of the clock, clear and trigger pins of the timer.
`timescale 1ns/100ps

module dct_pin_src (
  // Clock.
  input  wire logic pclk,
  // Pins towards the timer.
  output logic      ext_clock_pin,
  output logic      ext_clear_pin,
  output logic      trigger_pin
);
  // Every level is held four cycles so the three-stage synchroniser always sees it.
  initial begin
    ext_clock_pin = 1'b0;
    ext_clear_pin = 1'b0;
    trigger_pin   = 1'b0;
  end

  task automatic hold4();
    repeat (4) @(posedge pclk);
  endtask

  task automatic clk_cycles(input int n);
    for (int i = 0; i < n; i++) begin
      ext_clock_pin <= 1'b1;
      hold4();
      ext_clock_pin <= 1'b0;
      hold4();
    end
  endtask

  task automatic pulse_clear();
    ext_clear_pin <= 1'b1;
    hold4();
    ext_clear_pin <= 1'b0;
    hold4();
  endtask

  task automatic set_trig(input logic v);
    trigger_pin <= v;
    hold4();
  endtask
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the compare trigger timer.
`timescale 1ns/100ps
`include "dct_map.svh"

module tb_top;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_clock_pin;
  logic        ext_clear_pin;
  logic        trigger_pin;
  logic        wave_out_pin;
  logic        irq_match_a;
  logic        irq_match_b;
  logic        irq_overflow;
  int          n_fail;
  int          num_checks;
  logic [31:0] seed;
  logic [31:0] r;
  logic        e;
  int          d;

  dct_timer dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin(ext_clock_pin), .ext_clear_pin(ext_clear_pin), .trigger_pin(trigger_pin),
    .wave_out_pin(wave_out_pin), .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
    .irq_overflow(irq_overflow));

  dct_pin_src pins (.pclk(pclk), .ext_clock_pin(ext_clock_pin), .ext_clear_pin(ext_clear_pin),
    .trigger_pin(trigger_pin));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int exp_div(input int cks, input int sub);
    return 4 << (2 * (cks - 1) + sub);
  endfunction

  function automatic int exp_ext(input int cks, input int n);
    return (cks == 4) ? 0 : ((cks == 7) ? 2 * n : n);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h000000, v});
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  // Clearing a flag needs a status read first, then a write of zero.
  task automatic clr_flags(input logic [7:0] os);
    rd(`DCT_OFS_STATUS);
    wr(`DCT_OFS_STATUS, os);
  endtask

  // --------------------------------------------------------------------------
  // Clock, watchdog and tests
  // --------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    end_sim();
  end

  initial begin
    n_fail = 0;
    num_checks = 0;
    seed = 32'h154A66FF;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk(wave_out_pin, 1'b0);
    chk({irq_match_a, irq_match_b, irq_overflow}, 3'b000);
    rd(`DCT_OFS_COUNT);
    chk(r, 32'h00000000);
    rd(`DCT_OFS_CMP_A);
    chk(r, 32'h000000FF);
    rd(`DCT_OFS_CMP_B);
    chk(r, 32'h000000FF);
    rd(`DCT_OFS_CTRL0);
    chk(r, 32'h00000000);
    rd(`DCT_OFS_STATUS);
    chk(r, 32'h00000010);
    rd(`DCT_OFS_CTRL1);
    chk(r, 32'h000000E2);
    rd(8'h18);
    chk(e, 1'b1);
    chk(r, 32'h00000000);
    chk(pready, 1'b1);
    for (int k = 0; k < 3; k++) begin
      d = rnd() & 32'hFF;
      wr(8'(4 * k), 8'(d));
      rd(8'(4 * k));
      chk(r, d);
    end
    $display("test registers done");
    for (int c = 1; c < 4; c++) begin
      for (int s = 0; s < 2; s++) begin
        wr(`DCT_OFS_COUNT, 8'h00);
        wr(`DCT_OFS_CTRL1, 8'(s));
        wr(`DCT_OFS_CTRL0, 8'(c));
        repeat (512) @(posedge pclk);
        wr(`DCT_OFS_CTRL0, 8'h00);
        rd(`DCT_OFS_COUNT);
        chk_rng(r, 512 / exp_div(c, s) - 1, 520 / exp_div(c, s) + 1);
        repeat (64) @(posedge pclk);
        rd(`DCT_OFS_COUNT);
        chk_rng(r, 512 / exp_div(c, s) - 1, 520 / exp_div(c, s) + 1);
      end
    end
    wr(`DCT_OFS_CTRL1, 8'h00);
    $display("test internal clock done");
    for (int c = 4; c < 8; c++) begin
      d = 1 + (rnd() % 4);
      wr(`DCT_OFS_COUNT, 8'h00);
      wr(`DCT_OFS_CTRL0, 8'(c));
      pins.clk_cycles(d);
      repeat (6) @(posedge pclk);
      rd(`DCT_OFS_COUNT);
      chk(r, exp_ext(c, d));
    end
    $display("test external clock done");
    wr(`DCT_OFS_CTRL0, 8'h00);
    wr(`DCT_OFS_COUNT, 8'h40);
    wr(`DCT_OFS_CTRL0, 8'h18);
    rd(`DCT_OFS_COUNT);
    chk(r, 32'h00000040);
    pins.pulse_clear();
    repeat (6) @(posedge pclk);
    rd(`DCT_OFS_COUNT);
    chk(r, 32'h00000000);
    $display("test pin clear done");
    wr(`DCT_OFS_CTRL0, 8'h00);
    wr(`DCT_OFS_COUNT, 8'h00);
    wr(`DCT_OFS_CMP_A, 8'h10);
    wr(`DCT_OFS_CTRL1, 8'h0C);
    wr(`DCT_OFS_CTRL0, 8'h09);
    repeat (100) @(posedge pclk);
    rd(`DCT_OFS_COUNT);
    chk(r, 32'h00000000);
    pins.set_trig(1'b1);
    repeat (30) @(posedge pclk);
    rd(`DCT_OFS_COUNT);
    chk_rng(r, 1, 16);
    repeat (200) @(posedge pclk);
    rd(`DCT_OFS_COUNT);
    chk(r, 32'h00000000);
    wr(`DCT_OFS_CTRL1, 8'h00);
    $display("test trigger done");
    wr(`DCT_OFS_CTRL0, 8'h00);
    wr(`DCT_OFS_STATUS, 8'h00);
    wr(`DCT_OFS_COUNT, 8'h00);
    wr(`DCT_OFS_CMP_A, 8'h05);
    wr(`DCT_OFS_CTRL0, 8'h49);
    repeat (100) @(posedge pclk);
    wr(`DCT_OFS_CTRL0, 8'h40);
    rd(`DCT_OFS_COUNT);
    chk_rng(r, 0, 5);
    chk({irq_match_a, irq_match_b}, 2'b10);
    wr(`DCT_OFS_STATUS, 8'h00);
    rd(`DCT_OFS_STATUS);
    chk(r & 32'h40, 32'h00000040);
    wr(`DCT_OFS_STATUS, 8'h00);
    rd(`DCT_OFS_STATUS);
    chk(r & 32'h40, 32'h00000000);
    chk(irq_match_a, 1'b0);
    $display("test match flag done");
    wr(`DCT_OFS_CTRL0, 8'h00);
    clr_flags(8'h00);
    wr(`DCT_OFS_COUNT, 8'hF0);
    wr(`DCT_OFS_CTRL0, 8'h21);
    repeat (20) @(posedge pclk);
    wr(`DCT_OFS_CTRL0, 8'h20);
    rd(`DCT_OFS_STATUS);
    chk(r & 32'h20, 32'h00000000);
    chk(irq_overflow, 1'b0);
    wr(`DCT_OFS_CTRL0, 8'h21);
    repeat (60) @(posedge pclk);
    wr(`DCT_OFS_CTRL0, 8'h20);
    rd(`DCT_OFS_STATUS);
    chk(r & 32'h20, 32'h00000020);
    chk(irq_overflow, 1'b1);
    $display("test overflow done");
    for (int i = 0; i < 2; i++) begin
      wr(`DCT_OFS_CTRL0, 8'h00);
      clr_flags(8'h00);
      wr(i ? `DCT_OFS_CMP_B : `DCT_OFS_CMP_A, 8'h02);
      for (int code = 2; code > 0; code--) begin
        wr(`DCT_OFS_STATUS, 8'(code << (2 * i)));
        wr(`DCT_OFS_COUNT, 8'h00);
        wr(`DCT_OFS_CTRL0, i ? 8'h91 : 8'h49);
        repeat (20) @(posedge pclk);
        chk(i ? irq_match_b : irq_match_a, 1'b1);
        wr(`DCT_OFS_CTRL0, 8'h00);
        chk(wave_out_pin, code == 2);
      end
    end
    $display("test wave output done");
    end_sim();
  end
endmodule
